/* File: tmc_defs.svh */
// register offsets, field positions and reset values of the 16-bit timer
// assumes inclusion by bare name from the design module
`ifndef TMC_DEFS_SVH
`define TMC_DEFS_SVH
`define TMC_OFS_LOW 8'h0E
`define TMC_OFS_HIGH 8'h0F
`define TMC_OFS_CTRL 8'h10
`define TMC_OFS_FLAG 8'h0C
`define TMC_OFS_IEN 8'h8C
`define TMC_BIT_ON 0
`define TMC_BIT_CS 1
`define TMC_BIT_SYNCDIS 2
`define TMC_BIT_OSCEN 3
`define TMC_BIT_PS_LO 4
`define TMC_BIT_PS_HI 5
`define TMC_BIT_OVF 0
`define TMC_CTRL_RST 6'h00
`define TMC_CTRL_MASK 8'h3F
`define TMC_CNT_MAX 16'hFFFF
`define TMC_CNT_ZERO 16'h0000
`define TMC_BYTE_ZERO 8'h00
`define TMC_INSTR_DIV 2'h3
`define TMC_PS_ONE 3'h1
`endif

/* File: tmc_pkg.sv */
// types shared by the 16-bit timer design
// assumes tmc_defs.svh is reachable on the include path
package tmc_pkg;
  typedef enum logic [1:0] {
    TMC_PS_DIV1 = 2'b00,
    TMC_PS_DIV2 = 2'b01,
    TMC_PS_DIV4 = 2'b10,
    TMC_PS_DIV8 = 2'b11
  } tmc_prescale_t;
endpackage

/* File: tmc_timer.sv */
// 16-bit timer/counter with prescaler, overflow flag and enable
// assumes one 10 MHz clock, a plain register port and an async pin input
//
// Overview of operation
// - count kept as high and low bytes, both readable and writable
// - count increments upward and wraps from all ones to zero
// - each wrap sets overflow flag at bit zero of flag register
// - interrupt request raised only when flag and enable bit zero set
// - control bit one picks internal clock or external pin source
// - timer mode ticks once per instruction cycle, clock over four
// - counter mode counts external rising edges only
// - counting only while on bit set; clearing holds the count
// - internal clear input from capture/compare unit resets count
// - oscillator enable forces both oscillator pins to be inputs
// - two-bit prescale gives one, two, four or eight edges per step
// - external input synchronized when sync disable is zero
// - timer mode ignores sync disable and uses internal clock
// - two upper control bits read as zero
// - special event trigger clears both count bytes
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
`include "tmc_defs.svh"
module tmc_timer (
  input wire logic clk_i, // 10 MHz clock
  input wire logic resetn_i, // async reset, active low
  input wire logic [7:0] addr_i, // register address
  input wire logic [7:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [7:0] rdata_o, // read data, cycle after rd_i
  input wire logic ext_clk_i, // external clock pin, async
  input wire logic special_clear_i, // capture/compare clear pulse
  input wire logic [1:0] port_direction_i, // port direction bits 7:6
  output logic [1:0] pin_dir_o, // effective direction, 1 = input
  output logic osc_run_o, // oscillator enabled
  output logic irq_o // overflow interrupt request
);
  logic [5:0] ctrl_q;
  logic [15:0] count_q;
  logic flag_q;
  logic ien_q;
  logic [1:0] qdiv_q;
  logic [2:0] ps_q;
  logic ext_s1_q, ext_s2_q, ext_prev_q;
  logic ext_raw_q;
  logic src_edge, ps_tick, wrap;
  logic [2:0] ps_lim;
  logic ctrl_on, ctrl_cs, ctrl_sd;
  tmc_pkg::tmc_prescale_t ps_sel;

  assign ctrl_on = ctrl_q[`TMC_BIT_ON];
  assign ctrl_cs = ctrl_q[`TMC_BIT_CS];
  assign ctrl_sd = ctrl_q[`TMC_BIT_SYNCDIS];
  assign ps_sel = tmc_pkg::tmc_prescale_t'(
    {ctrl_q[`TMC_BIT_PS_HI], ctrl_q[`TMC_BIT_PS_LO]});

  // external pin synchroniser; first stage read only by the second
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_clk_i;
      ext_s2_q <= ext_s1_q;
    end
  end

  // unsynchronised path still passes two flops per house style; it
  // differs by skipping the extra resample stage (one cycle less delay)
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_raw_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_raw_q <= ext_s2_q;
      ext_prev_q <= ctrl_sd ? ext_s2_q : ext_raw_q;
    end
  end

  // instruction cycle divider: clock over four
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      qdiv_q <= 2'h0;
    end else begin
      qdiv_q <= qdiv_q + 2'h1;
    end
  end

  always_comb begin
    if (!ctrl_cs) begin
      src_edge = (qdiv_q == `TMC_INSTR_DIV);
    end else if (ctrl_sd) begin
      src_edge = ext_s2_q & ~ext_prev_q;
    end else begin
      src_edge = ext_raw_q & ~ext_prev_q;
    end
  end

  always_comb begin
    unique case (ps_sel)
      tmc_pkg::TMC_PS_DIV1: ps_lim = 3'h0;
      tmc_pkg::TMC_PS_DIV2: ps_lim = 3'h1;
      tmc_pkg::TMC_PS_DIV4: ps_lim = 3'h3;
      tmc_pkg::TMC_PS_DIV8: ps_lim = 3'h7;
    endcase
  end

  assign ps_tick = ctrl_on && src_edge && (ps_q == ps_lim);
  assign wrap = ps_tick && (count_q == `TMC_CNT_MAX);

  // prescaler, cleared by writes to the count as in the real part
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ps_q <= 3'h0;
    end else if (wr_i && (addr_i == `TMC_OFS_LOW ||
                          addr_i == `TMC_OFS_HIGH)) begin
      ps_q <= 3'h0;
    end else if (ctrl_on && src_edge) begin
      ps_q <= (ps_q == ps_lim) ? 3'h0 : ps_q + `TMC_PS_ONE;
    end
  end

  // count: clear beats software write beats increment
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_q <= `TMC_CNT_ZERO;
    end else if (special_clear_i) begin
      count_q <= `TMC_CNT_ZERO;
    end else if (wr_i && addr_i == `TMC_OFS_LOW) begin
      count_q[7:0] <= wdata_i;
    end else if (wr_i && addr_i == `TMC_OFS_HIGH) begin
      count_q[15:8] <= wdata_i;
    end else if (ps_tick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= `TMC_CTRL_RST;
    end else if (wr_i && addr_i == `TMC_OFS_CTRL) begin
      ctrl_q <= wdata_i[5:0];
    end
  end

  // overflow flag: a wrap in the same cycle as a clear write wins
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_q <= 1'b0;
    end else if (wrap) begin
      flag_q <= 1'b1;
    end else if (wr_i && addr_i == `TMC_OFS_FLAG) begin
      flag_q <= wdata_i[`TMC_BIT_OVF];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ien_q <= 1'b0;
    end else if (wr_i && addr_i == `TMC_OFS_IEN) begin
      ien_q <= wdata_i[`TMC_BIT_OVF];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (flag_q | wrap) & ien_q;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_dir_o <= 2'b11;
      osc_run_o <= 1'b0;
    end else begin
      osc_run_o <= ctrl_q[`TMC_BIT_OSCEN];
      pin_dir_o <= ctrl_q[`TMC_BIT_OSCEN] ? 2'b11 : port_direction_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= `TMC_BYTE_ZERO;
    end else if (rd_i) begin
      unique case (addr_i)
        `TMC_OFS_LOW: rdata_o <= count_q[7:0];
        `TMC_OFS_HIGH: rdata_o <= count_q[15:8];
        `TMC_OFS_CTRL: rdata_o <= {2'b00, ctrl_q};
        `TMC_OFS_FLAG: rdata_o <= {7'h00, flag_q};
        `TMC_OFS_IEN: rdata_o <= {7'h00, ien_q};
        default: rdata_o <= `TMC_BYTE_ZERO;
      endcase
    end else begin
      rdata_o <= `TMC_BYTE_ZERO;
    end
  end

  // assertions
  property wrap_flag_p;
    @(posedge clk_i) disable iff (!resetn_i)
      wrap |=> flag_q;
  endproperty
  wrap_sets_flag_a: assert property (wrap_flag_p)
    else $error("overflow flag not set after wrap");

  irq_gate_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    irq_o |-> $past(ien_q))
    else $error("irq without enable");

  hold_when_off_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    (!ctrl_on && !wr_i && !special_clear_i) |=> $stable(count_q))
    else $error("count moved while off");

  clear_count_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    special_clear_i |=> count_q == `TMC_CNT_ZERO)
    else $error("special clear did not zero count");

  wrap_zero_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (wrap && !special_clear_i && !wr_i) |=> count_q == `TMC_CNT_ZERO)
    else $error("wrap did not yield zero");

  pin_input_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ctrl_q[`TMC_BIT_OSCEN] |=> pin_dir_o == 2'b11)
    else $error("osc pins not inputs");

  ctrl_read_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (rd_i && addr_i == `TMC_OFS_CTRL) |=> rdata_o[7:6] == 2'b00)
    else $error("upper control bits not zero");

  timer_rate_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!ctrl_cs && src_edge) |=> (!src_edge || ctrl_cs) [*3])
    else $error("timer ticks faster than clock over four");

  ps_div_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ps_tick && ps_sel == tmc_pkg::TMC_PS_DIV8) |-> ps_q == 3'h7)
    else $error("prescale eight not honoured");

  // named steps of a register access, reused by the checks below
  sequence low_wr_s;
    wr_i && addr_i == `TMC_OFS_LOW && !special_clear_i;
  endsequence
  sequence high_wr_s;
    wr_i && addr_i == `TMC_OFS_HIGH && !special_clear_i;
  endsequence
  sequence cnt_wr_s;
    wr_i && (addr_i == `TMC_OFS_LOW || addr_i == `TMC_OFS_HIGH);
  endsequence
  sequence flag_wr_s;
    wr_i && addr_i == `TMC_OFS_FLAG && !wrap;
  endsequence

  low_write_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    low_wr_s |=> count_q[7:0] == $past(wdata_i))
    else $error("low byte write lost");

  high_write_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    high_wr_s |=> count_q[15:8] == $past(wdata_i))
    else $error("high byte write lost");

  low_read_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (rd_i && addr_i == `TMC_OFS_LOW) |=> rdata_o == $past(count_q[7:0]))
    else $error("low byte read wrong");

  high_read_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (rd_i && addr_i == `TMC_OFS_HIGH) |=> rdata_o == $past(count_q[15:8]))
    else $error("high byte read wrong");

  ctrl_full_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (rd_i && addr_i == `TMC_OFS_CTRL) |=> rdata_o == {2'b00, $past(ctrl_q)})
    else $error("control read wrong");

  step_inc_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (ps_tick && !special_clear_i && !wr_i) |=> count_q == $past(count_q) + 16'h0001)
    else $error("count did not step by one");

  off_no_tick_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    !ctrl_on |-> !ps_tick)
    else $error("tick while off");

  timer_src_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    !ctrl_cs |-> src_edge == (qdiv_q == `TMC_INSTR_DIV))
    else $error("timer mode not on internal clock");

  rdata_idle_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    !rd_i |=> rdata_o == `TMC_BYTE_ZERO)
    else $error("read data without strobe");

  irq_follow_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (flag_q && ien_q) |=> irq_o)
    else $error("enabled flag gave no request");

  dir_pass_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    !ctrl_q[`TMC_BIT_OSCEN] |=> pin_dir_o == $past(port_direction_i))
    else $error("port direction not passed");

  ps_step_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (ctrl_on && src_edge && ps_q != ps_lim && !wr_i) |=> ps_q == $past(ps_q) + 3'h1)
    else $error("prescaler did not step");

  ps_clear_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    cnt_wr_s |=> ps_q == 3'h0)
    else $error("count write left prescaler");

  flag_write_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    flag_wr_s |=> flag_q == $past(wdata_i[`TMC_BIT_OVF]))
    else $error("flag write lost");

  ien_write_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (wr_i && addr_i == `TMC_OFS_IEN) |=> ien_q == $past(wdata_i[`TMC_BIT_OVF]))
    else $error("enable write lost");
endmodule

/* File: tmc_ext_src.sv */
// model of the external clock source on the counter pin
// assumes the bench calls burst; the pin rests low between bursts
`timescale 1ns/10ps
module tmc_ext_src (
  output logic ext_clk_o // clock pin to the timer
);
  initial ext_clk_o = 1'b0;
  // free of the bench clock so edges land at any phase
  task automatic burst(input int n, input int half);
    repeat (n) begin
      #(half) ext_clk_o = 1'b1;
      #(half) ext_clk_o = 1'b0;
    end
  endtask
endmodule

/* File: tb.sv */
// self-checking bench for the 16-bit timer/counter
// assumes tmc_timer and tmc_ext_src are compiled before it
`timescale 1ns/10ps
module tb;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic special_clear_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o, r;
  logic [1:0] port_direction_i = 2'b01;
  logic [1:0] pin_dir_o;
  logic ext_clk, osc_run_o, irq_o;
  logic [15:0] v, w;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  integer seed = 32'hec32_b690;
  always #50 clk_i = ~clk_i;
  tmc_ext_src src (.ext_clk_o(ext_clk));
  tmc_timer dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ext_clk_i(ext_clk), .special_clear_i(special_clear_i),
    .port_direction_i(port_direction_i), .pin_dir_o(pin_dir_o),
    .osc_run_o(osc_run_o), .irq_o(irq_o));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic wr16(input logic [15:0] c);
    wr(8'h0E, c[7:0]);
    wr(8'h0F, c[15:8]);
  endtask
  task automatic rd16(output logic [15:0] c);
    rd(8'h0E, c[7:0]);
    rd(8'h0F, c[15:8]);
  endtask
  // t gives slack for the start phase of the divide-by-four tick
  task automatic chk(input string s, input logic [15:0] e, g, input int t);
    checks_done++;
    if ((^g) === 1'bx || g > e + t || g + t < e) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(8'h10, r);
    chk("ctrl_rst", 16'h0000, r, 0);
    chk("dir", 16'h0001, pin_dir_o, 0);
    rd(8'h55, r);
    chk("unmapped", 16'h0000, r, 0);
    wr(8'h10, 8'hFF);
    rd(8'h10, r);
    chk("ctrl", 16'h003F, r, 0);
    chk("dir_osc", 16'h0003, pin_dir_o, 0);
    chk("osc", 16'h0001, osc_run_o, 0);
    wr(8'h10, 8'h00);
    v = 16'($random(seed));
    wr16(v);
    repeat (50) @(posedge clk_i);
    w = v;
    rd16(v);
    chk("hold", w, v, 0);
    wr16(16'hA55A);
    repeat (30) @(posedge clk_i);
    rd16(v);
    chk("bytes", 16'hA55A, v, 0);
    for (int p = 0; p < 4; p++) begin
      wr16(16'h0000);
      wr(8'h10, 8'(1 | p << 4 | ($random(seed) & 4)));
      repeat (240) @(posedge clk_i);
      wr(8'h10, 8'h00);
      rd16(v);
      chk("tmr_ps", 16'(240 / (4 << p)), v, 1);
    end
    for (int s = 0; s < 2; s++) begin
      n = 1 + ($random(seed) & 15);
      wr16(16'h0000);
      wr(8'h10, 8'(3 | s << 2 | s << 5));
      src.burst(n, 330);
      repeat (10) @(posedge clk_i);
      wr(8'h10, 8'h00);
      rd16(v);
      chk("ext", 16'(n >> (2 * s)), v, 0);
    end
    wr(8'h0C, 8'h00);
    wr(8'h8C, 8'h01);
    wr16(16'hFFFF);
    wr(8'h10, 8'h01);
    repeat (20) @(posedge clk_i);
    wr(8'h10, 8'h00);
    rd16(v);
    chk("wrap", 16'h0004, v, 1);
    rd(8'h0C, r);
    chk("flag", 16'h0001, r[0], 0);
    chk("irq", 16'h0001, irq_o, 0);
    wr(8'h8C, 8'h00);
    repeat (2) @(posedge clk_i);
    #1 chk("irq_mask", 16'h0000, irq_o, 0);
    wr(8'h8C, 8'h01);
    wr(8'h0C, 8'h00);
    repeat (2) @(posedge clk_i);
    #1 chk("irq_clr", 16'h0000, irq_o, 0);
    wr16(16'($random(seed)));
    @(posedge clk_i);
    special_clear_i <= 1'b1;
    @(posedge clk_i);
    special_clear_i <= 1'b0;
    rd16(v);
    chk("clear", 16'h0000, v, 0);
    tally_and_finish;
  end
endmodule
